// ### design/ghsi_highway.sv
// gci highway slot port: strap capture, frame timing, subframe transmit and receive
// assumes HWY_CLK and FRAME_STROBE/DATA_RX come from the upstream controller on one clock,
// and a register master on SYS_CLK with one-cycle strobes and read data one cycle later
// Functional notes
// [RULE1] straps latched when reset is released
// [RULE2] mode high pcm; rate picks clock speed
// [RULE3] pcm and gci share four highway pins
// [RULE4] gci: serial control pins become selectors
// [RULE5] subframe equals seven minus selector value
// [RULE6] board holds selector pins static
// [RULE7] transmit and receive only in own subframe
// [RULE8] host supplies matching bit clock, 8 kHz
// [RULE9] frame strobe rising edge starts frame
// [RULE10] double rate counts twice the clocks
// [RULE11] eight equal subframes per frame
// [RULE12] four bytes: two voice, monitor, control
// [RULE13] control byte: six bits plus handshake
// [RULE14] handshake bits pace monitor bytes
// [RULE15] idle after two quiet handshake frames
// [RULE16] byte order fixed, msb first
// [RULE17] transmit line released outside own subframe
module ghsi_highway
    import ghsi_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        MODE_STRAP,
    input  wire logic        RATE_STRAP,
    input  wire logic        SLOT_SEL0,
    input  wire logic        SLOT_SEL1,
    input  wire logic        SLOT_SEL2,
    input  wire logic        HWY_CLK,
    input  wire logic        FRAME_STROBE,
    input  wire logic        DATA_RX,
    output logic             DATA_TX,
    output logic             DATA_TX_OE,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA
);
    import ghsi_pkg::*;

    // ---------------- system domain state ----------------
    logic [STRAP_W-1:0] strap_sync;     // straps after two stages
    logic [1:0]  strap_cnt;             // wait after reset release
    logic        strap_done;            // straps captured
    logic        gci_mode;              // captured: gci operation
    logic        double_rate;           // captured: double bit clock
    logic [2:0]  subframe;              // captured subframe number
    logic [15:0] tx_voice;              // software transmit bytes
    logic [15:0] tx_monsc;
    logic [15:0] rx_voice;              // last received bytes
    logic [15:0] rx_monsc;
    logic [31:0] tx_snap;               // word the link reads, held across a frame
    logic        frame_flag;            // sticky new-frame flag
    logic [1:0]  idle_cnt;              // quiet handshake frames, saturating
    logic        evt_tgl_s;             // synchronised link toggle
    logic        evt_tgl_d;             // delayed for edge detect
    logic        frame_evt;             // one-cycle frame event
    logic [15:0] rdata;
    logic [1:0]  next_strap_cnt;
    logic        next_strap_done;
    logic        next_gci_mode;
    logic        next_double_rate;
    logic [2:0]  next_subframe;
    logic [15:0] next_tx_voice;
    logic [15:0] next_tx_monsc;
    logic [15:0] next_rx_voice;
    logic [15:0] next_rx_monsc;
    logic [31:0] next_tx_snap;
    logic        next_frame_flag;
    logic [1:0]  next_idle_cnt;
    logic [15:0] next_rdata;
    logic        hs_quiet;              // all four handshake bits inactive

    // ---------------- link domain state ----------------
    logic [4:0]      l_straps;          // gci, double, subframe in link domain
    logic            l_gci;
    logic            l_rate;
    logic [2:0]      l_sub;
    logic            fs_prev;           // strobe one clock earlier
    logic            frame_start;       // rising edge of frame strobe
    logic [CNT_W-1:0] cnt;              // clock position in frame
    logic [31:0]     rx_shift;          // bits of own subframe
    logic [31:0]     rx_hold;           // finished subframe, stable for a frame
    logic            evt_tgl;           // flips once per received subframe
    logic            dtx;
    logic            dtx_oe;
    logic [CNT_W-1:0] next_cnt;
    logic [31:0]     next_rx_shift;
    logic [31:0]     next_rx_hold;
    logic            next_evt_tgl;
    logic            next_dtx;
    logic            next_dtx_oe;
    logic [7:0]      cur_idx;           // bit index of current period
    logic [7:0]      nxt_idx;           // bit index of next period
    logic            sample_now;        // end of a data bit period
    logic            framed;            // a frame start has been seen in gci mode since reset
    logic            next_framed;

    // bit index from a clock position; double rate spends two clocks per bit
    function automatic logic [7:0] bit_index(input logic [CNT_W-1:0] pos, input logic dbl);
        bit_index = dbl ? pos[8:1] : pos[7:0];
    endfunction

    // [RULE4] selector pins read as straps, never as serial port
    ghsi_sync2 #(.WIDTH(STRAP_W)) u_strap_sync (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .d   ({SLOT_SEL2, SLOT_SEL1, SLOT_SEL0, RATE_STRAP, MODE_STRAP}),
        .q   (strap_sync)
    );

    // link toggle into system domain
    ghsi_sync2 #(.WIDTH(1)) u_evt_sync (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .d   (evt_tgl),
        .q   (evt_tgl_s)
    );

    // captured straps into link domain; static once captured
    ghsi_sync2 #(.WIDTH(5)) u_cfg_sync (
        .clk (HWY_CLK),
        .rst (SYS_RST),
        .d   ({subframe, double_rate, gci_mode & strap_done}),
        .q   (l_straps)
    );

    assign l_gci  = l_straps[0];
    assign l_rate = l_straps[1];
    assign l_sub  = l_straps[4:2];

    assign frame_evt = evt_tgl_s ^ evt_tgl_d;
    // [RULE15] quiet when both directions leave both handshake bits inactive
    assign hs_quiet = (rx_monsc[SIG_RX_ACK] == HS_INACTIVE)
                   && (rx_monsc[SIG_TX_FLAG] == HS_INACTIVE)
                   && (tx_monsc[SIG_RX_ACK] == HS_INACTIVE)
                   && (tx_monsc[SIG_TX_FLAG] == HS_INACTIVE);

    // system next values: straps, registers, frame bookkeeping
    always_comb
    begin
        next_strap_cnt   = strap_cnt;
        next_strap_done  = strap_done;
        next_gci_mode    = gci_mode;
        next_double_rate = double_rate;
        next_subframe    = subframe;
        next_tx_voice    = tx_voice;
        next_tx_monsc    = tx_monsc;
        next_rx_voice    = rx_voice;
        next_rx_monsc    = rx_monsc;
        next_tx_snap     = tx_snap;
        next_frame_flag  = frame_flag;
        next_idle_cnt    = idle_cnt;
        next_rdata       = 16'h0000;
        // [RULE1] capture once, after sync stages have filled
        if (!strap_done)
        begin
            if (strap_cnt == STRAP_WAIT)
            begin
                next_strap_done  = 1'b1;
                // [RULE2] mode high forces pcm, rate ignored there
                next_gci_mode    = !strap_sync[STRAP_MODE];
                next_double_rate = !strap_sync[STRAP_MODE] && strap_sync[STRAP_RATE];
                // [RULE5] subframe is seven minus selector value
                next_subframe    = SUB_TOP - strap_sync[STRAP_SEL0 +: 3];
            end
            else
            begin
                next_strap_cnt = strap_cnt + 2'h1;
            end
        end
        // register writes
        if (REG_WR && (REG_ADDR == ADR_TX_VOICE))
        begin
            next_tx_voice = REG_WDATA;
        end
        if (REG_WR && (REG_ADDR == ADR_TX_MONSC))
        begin
            next_tx_monsc = REG_WDATA;
        end
        // reads; status read clears the frame flag
        if (REG_RD)
        begin
            case (REG_ADDR)
                ADR_TX_VOICE: next_rdata = tx_voice;
                ADR_TX_MONSC: next_rdata = tx_monsc;
                ADR_RX_VOICE: next_rdata = rx_voice;
                ADR_RX_MONSC: next_rdata = rx_monsc;
                ADR_STATUS:
                begin
                    next_rdata[ST_GCI]              = gci_mode;
                    next_rdata[ST_DOUBLE]           = double_rate;
                    next_rdata[ST_SUB_LO +: 3]      = subframe;
                    next_rdata[ST_IDLE]             = (idle_cnt >= IDLE_FRAMES);
                    next_rdata[ST_FRAME]            = frame_flag;
                    next_rdata[ST_READY]            = strap_done;
                    next_frame_flag                 = 1'b0;
                end
                default: next_rdata = 16'h0000;   // unmapped reads zero
            endcase
        end
        // frame event: take received word, hand next word to link
        if (frame_evt)
        begin
            // [RULE12] voice bytes high, monitor then control low
            next_rx_voice   = rx_hold[31:16];
            next_rx_monsc   = rx_hold[15:0];
            next_tx_snap    = {tx_voice, tx_monsc};
            next_frame_flag = 1'b1;              // set wins over read clear
            // [RULE15] count quiet frames, saturating
            if (hs_quiet)
            begin
                if (idle_cnt != IDLE_FRAMES)
                begin
                    next_idle_cnt = idle_cnt + 2'h1;
                end
            end
            else
            begin
                next_idle_cnt = 2'h0;
            end
        end
    end

    // system registers
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            strap_cnt   <= 2'h0;
            strap_done  <= 1'b0;
            gci_mode    <= 1'b0;
            double_rate <= 1'b0;
            subframe    <= 3'h0;
            tx_voice    <= TX_RESET;
            tx_monsc    <= TX_RESET;
            rx_voice    <= TX_RESET;
            rx_monsc    <= TX_RESET;
            tx_snap     <= WORD_IDLE;
            frame_flag  <= 1'b0;
            idle_cnt    <= 2'h0;
            evt_tgl_d   <= 1'b0;
            rdata       <= 16'h0000;
        end
        else
        begin
            strap_cnt   <= next_strap_cnt;
            strap_done  <= next_strap_done;
            gci_mode    <= next_gci_mode;
            double_rate <= next_double_rate;
            subframe    <= next_subframe;
            tx_voice    <= next_tx_voice;
            tx_monsc    <= next_tx_monsc;
            rx_voice    <= next_rx_voice;
            rx_monsc    <= next_rx_monsc;
            tx_snap     <= next_tx_snap;
            frame_flag  <= next_frame_flag;
            idle_cnt    <= next_idle_cnt;
            evt_tgl_d   <= evt_tgl_s;
            rdata       <= next_rdata;
        end
    end

    assign REG_RDATA = rdata;

    // [RULE9] new frame on strobe rising edge
    assign frame_start = FRAME_STROBE && !fs_prev;
    // [RULE10] double rate: two clocks per bit, same layout
    assign cur_idx    = bit_index(cnt, l_rate);
    assign sample_now = !l_rate || cnt[0];

    // link next values: position, receive shift, transmit bit
    always_comb
    begin
        next_cnt      = frame_start ? '0 : cnt + 1'b1;
        nxt_idx       = bit_index(next_cnt, l_rate);
        next_rx_shift = rx_shift;
        next_rx_hold  = rx_hold;
        next_evt_tgl  = evt_tgl;
        // position is meaningless until a strobe has aligned it
        next_framed   = framed || (frame_start && l_gci);
        // [RULE7] capture only in own subframe, gci only
        // [RULE11] top three index bits name the subframe
        if (l_gci && framed && (cur_idx[7:5] == l_sub) && sample_now)
        begin
            next_rx_shift = {rx_shift[30:0], DATA_RX};
            if (cur_idx[4:0] == SUB_LAST)
            begin
                next_rx_hold = {rx_shift[30:0], DATA_RX};
                next_evt_tgl = !evt_tgl;
            end
        end
        // [RULE17] drive only own subframe; [RULE3] pcm leaves pins to pcm port
        next_dtx_oe = l_gci && next_framed && (nxt_idx[7:5] == l_sub);
        // [RULE16] msb first, first voice byte leads
        // [RULE13] control byte carries command and handshake bits as written
        // [RULE14] handshake pacing left to software through those bits
        next_dtx    = next_dtx_oe ? tx_snap[~nxt_idx[4:0]] : 1'b0;
    end

    // link registers; [RULE8] relies on host clock matching rate strap
    always_ff @(posedge HWY_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            fs_prev  <= 1'b0;
            cnt      <= '0;
            rx_shift <= DATA_ZERO;
            rx_hold  <= WORD_IDLE;
            evt_tgl  <= 1'b0;
            framed   <= 1'b0;
            dtx      <= 1'b0;
            dtx_oe   <= 1'b0;
        end
        else
        begin
            fs_prev  <= FRAME_STROBE;
            cnt      <= next_cnt;
            rx_shift <= next_rx_shift;
            rx_hold  <= next_rx_hold;
            evt_tgl  <= next_evt_tgl;
            framed   <= next_framed;
            dtx      <= next_dtx;
            dtx_oe   <= next_dtx_oe;
        end
    end

    assign DATA_TX    = dtx;
    assign DATA_TX_OE = dtx_oe;

    // helper: length of each drive window
    logic [7:0] oe_len;
    always_ff @(posedge HWY_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            oe_len <= 8'h00;
        end
        else
        begin
            oe_len <= dtx_oe ? oe_len + 8'h01 : 8'h00;
        end
    end

    // checks
    property p_strap_hold;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        strap_done |=> $stable(gci_mode) && $stable(double_rate) && $stable(subframe);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("straps changed after capture"); // [RULE1]

    property p_mode_map;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        $rose(strap_done) |-> (gci_mode == !$past(strap_sync[STRAP_MODE]))
            && (double_rate == ($past(strap_sync[STRAP_RATE]) && gci_mode));
    endproperty
    a_mode_map: assert property (p_mode_map) else $error("mode or rate wrong"); // [RULE2]

    property p_sub_map;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        $rose(strap_done) |-> subframe == 3'(7 - $past(strap_sync[4:2]));
    endproperty
    a_sub_map: assert property (p_sub_map) else $error("subframe not seven minus select"); // [RULE5]

    property p_oe_slot;
        @(posedge HWY_CLK) disable iff (SYS_RST)
        dtx_oe |-> l_gci && (cur_idx[7:5] == l_sub);
    endproperty
    a_oe_slot: assert property (p_oe_slot) else $error("driving outside own subframe"); // [RULE17]

    property p_frame_start;
        @(posedge HWY_CLK) disable iff (SYS_RST)
        frame_start |=> (cnt == '0) ##1 (cnt == 9'h001);
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame did not restart"); // [RULE9]

    property p_win_len;
        @(posedge HWY_CLK) disable iff (SYS_RST)
        $fell(dtx_oe) && !$past(frame_start) && $stable(l_straps)
            |-> $past(oe_len) == (l_rate ? 8'(LEN_DOUBLE - 1) : 8'(LEN_SINGLE - 1));
    endproperty
    a_win_len: assert property (p_win_len) else $error("subframe window length wrong"); // [RULE10]

    property p_msb_first;
        @(posedge HWY_CLK) disable iff (SYS_RST)
        $rose(dtx_oe) && (cur_idx[4:0] == 5'h00) |-> dtx == tx_snap[31];
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit not voice msb"); // [RULE16]

    property p_rx_take;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        frame_evt |=> (rx_monsc == $past(rx_hold[15:0])) && frame_flag;
    endproperty
    a_rx_take: assert property (p_rx_take) else $error("received word not taken"); // [RULE12]

    property p_idle;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        frame_evt && !hs_quiet |=> idle_cnt == 2'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("idle count not cleared"); // [RULE15]
endmodule

// ### design/ghsi_pkg.sv
// constants for the gci highway slot interface: straps, frame timing, sc layout, registers
// assumes a 20 MHz system clock and a highway bit clock from the upstream controller
package ghsi_pkg;

    // system clock figures
    localparam int SYS_CLK_HZ       = 20_000_000;   // system clock rate
    localparam int FRAME_US         = 125;          // highway frame length
    localparam int FRAME_SYS_CYCLES = (FRAME_US * (SYS_CLK_HZ / 1_000_000)); // frame in sys clocks

    // highway geometry
    localparam int SUBFRAMES        = 8;            // subframes per frame
    localparam int BITS_PER_SUB     = 32;           // four bytes per subframe
    localparam int CNT_W            = 9;            // clock positions, 512 in double rate
    localparam logic [2:0] SUB_TOP  = 3'h7;         // subframe = top minus selector value
    localparam logic [4:0] SUB_LAST = 5'h1f;        // last bit of a subframe
    localparam int LEN_SINGLE       = 32;           // drive cycles per subframe, single rate
    localparam int LEN_DOUBLE       = 64;           // drive cycles per subframe, double rate

    // strap capture after reset release: two sync stages plus margin
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // strap bit positions in the synchronised strap bus
    localparam int STRAP_MODE = 0;                  // interface mode strap, high = pcm
    localparam int STRAP_RATE = 1;                  // bit-clock rate strap, high = double
    localparam int STRAP_SEL0 = 2;                  // slot selector bits 0..2
    localparam int STRAP_W    = 5;

    // signalling/control byte layout
    localparam int SIG_CI_HI   = 7;                 // command/indicate bits 7..2
    localparam int SIG_CI_LO   = 2;
    localparam int SIG_RX_ACK  = 1;                 // monitor receive acknowledge
    localparam int SIG_TX_FLAG = 0;                 // monitor transmit flag
    localparam logic HS_INACTIVE = 1'b1;            // handshake bits are active low
    localparam logic [1:0] IDLE_FRAMES = 2'h2;      // frames of quiet handshake for idle

    // register map, byte addresses
    localparam logic [7:0] ADR_TX_VOICE  = 8'h00;   // [15:8] first voice, [7:0] second voice
    localparam logic [7:0] ADR_TX_MONSC  = 8'h04;   // [15:8] monitor, [7:0] signalling/control
    localparam logic [7:0] ADR_RX_VOICE  = 8'h08;
    localparam logic [7:0] ADR_RX_MONSC  = 8'h0c;
    localparam logic [7:0] ADR_STATUS    = 8'h10;

    // status bits
    localparam int ST_GCI    = 0;                   // gci operation selected
    localparam int ST_DOUBLE = 1;                   // double-rate bit clock
    localparam int ST_SUB_LO = 2;                   // subframe number bits 4..2
    localparam int ST_IDLE   = 5;                   // monitor channel idle
    localparam int ST_FRAME  = 6;                   // new frame received, clears on read
    localparam int ST_READY  = 7;                   // straps captured

    // reset values
    localparam logic [15:0] TX_RESET   = 16'hffff;  // idle highway: ones, handshake inactive
    localparam logic [31:0] WORD_IDLE  = 32'hffff_ffff;
    localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

endpackage

// ### design/ghsi_sync2.sv
// two flip-flop level synchroniser, one bit per lane
// assumes each lane is a slow level or a toggle; words need their own handshake
module ghsi_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;       // first stage, read only by the second
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // next values: plain shift
    always_comb
    begin
        next_meta = d;
        next_q    = meta;
    end

    // both stages
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

// ### test/ghsi_highway_tb.sv
// self-checking bench for the gci highway slot port
// assumes the host model supplies bit clock and frame strobe
module ghsi_highway_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ghsi_pkg::*;

    logic        sys_clk, sys_rst, mode_strap, rate_strap;
    logic [2:0]  sel;
    logic        hwy_clk, frame_strobe, data_rx, data_tx, data_tx_oe, reg_wr, reg_rd;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rdat;
    logic [31:0] tx_word;
    logic [9:0]  run, start, bad;
    int          miscompares, n_tests;
    wire  [2:0]  sub = SUB_TOP - sel;       // expected subframe

    ghsi_highway ghsi_highway_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
        .MODE_STRAP(mode_strap), .RATE_STRAP(rate_strap), .SLOT_SEL0(sel[0]),
        .SLOT_SEL1(sel[1]), .SLOT_SEL2(sel[2]), .HWY_CLK(hwy_clk),
        .FRAME_STROBE(frame_strobe), .DATA_RX(data_rx), .DATA_TX(data_tx),
        .DATA_TX_OE(data_tx_oe), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

    ghsi_host_model ghsi_host_model_inst (.hwy_clk(hwy_clk), .rst(sys_rst),
        .dbl(rate_strap), .sub(sub), .rx_word(32'ha55a_c3f3), .frame_strobe(frame_strobe),
        .data_rx(data_rx), .data_tx(data_tx), .data_tx_oe(data_tx_oe),
        .tx_word(tx_word), .run(run), .start(start), .bad(bad));

    // 50 ns system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data is taken in the cycle after the strobe only
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp, what);
    endtask

    // reset with straps set, move the mode strap later, load a word, run three frames
    task automatic run_cfg(input logic m, input logic r, input logic [2:0] s);
        @(posedge sys_clk);
        mode_strap <= m;
        rate_strap <= r;
        // selectors move only while reset is held
        sel        <= s;
        sys_rst    <= 1'b1;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        mode_strap <= ~m;
        wr(ADR_TX_VOICE, 16'h5ac3);
        wr(ADR_TX_MONSC, 16'h3cff);
        repeat (3) @(negedge frame_strobe);
        // gci: let the own window in flight finish before anything is compared
        if (!m)
            @(negedge data_tx_oe);
        repeat (5) @(posedge sys_clk);
    endtask

    task automatic gci_chk(input logic [9:0] len);
        rdchk(ADR_STATUS, {8'h00, 3'b111, sub, rate_strap, 1'b1}, "status");
        rdchk(ADR_STATUS, {8'h00, 3'b101, sub, rate_strap, 1'b1}, "reread");
        chk(tx_word, 32'h5ac3_3cff, "tx word");
        chk(run, len, "window length");
        chk(start, len * sub, "window start");
        chk(bad, 32'h0, "drive outside slot");
        rdchk(ADR_RX_VOICE, 16'ha55a, "rx voice");
        rdchk(ADR_RX_MONSC, 16'hc3f3, "rx monitor and control");
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard: all configurations need well under half of this
    initial
    begin
        #2_000_000;
        miscompares++;
        test_done;
    end

    initial
    begin
        {sys_rst, mode_strap, rate_strap, reg_wr, reg_rd} = 5'b10000;
        sel = 3'b111;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        miscompares = 0;
        n_tests = 0;
        run_cfg(1'b0, 1'b0, 3'b111);
        gci_chk(10'h020);
        // receive word is read-only, unmapped place reads zero, data stands one cycle
        wr(8'h20, 16'h1234);
        rdchk(8'h20, 16'h0000, "unmapped");
        wr(ADR_RX_VOICE, 16'h0000);
        rdchk(ADR_RX_VOICE, 16'ha55a, "rx read-only");
        @(posedge sys_clk);
        #1 chk(reg_rdata, 32'h0, "read data one cycle");
        // active transmit flag ends monitor idle
        wr(ADR_TX_MONSC, 16'h3cfe);
        repeat (3) @(negedge frame_strobe);
        repeat (5) @(posedge sys_clk);
        rdchk(ADR_STATUS, 16'h00c1, "monitor busy");
        $display("test gci single subframe 0 done");
        run_cfg(1'b0, 1'b1, 3'b000);
        gci_chk(10'h040);
        $display("test gci double subframe 7 done");
        run_cfg(1'b0, 1'b0, 3'b101);
        gci_chk(10'h020);
        $display("test gci single subframe 2 done");
        run_cfg(1'b1, 1'b0, 3'b111);
        rdchk(ADR_STATUS, 16'h0080, "pcm status");
        chk(run, 32'h0, "pcm no drive");
        rdchk(ADR_RX_VOICE, 16'hffff, "pcm no capture");
        $display("test pcm done");
        test_done;
    end
endmodule

// ### test/ghsi_host_model.sv
// upstream highway controller model: bit clock, frame strobe, receive data, transmit capture
// assumes the port under test samples and launches on rising hwy_clk edges
module ghsi_host_model
(
    output logic        hwy_clk,
    input  wire logic   rst,
    input  wire logic   dbl,
    input  wire logic [2:0]  sub,
    input  wire logic [31:0] rx_word,
    output logic        frame_strobe,
    output logic        data_rx,
    input  wire logic   data_tx,
    input  wire logic   data_tx_oe,
    output logic [31:0] tx_word,
    output logic [9:0]  run,
    output logic [9:0]  start,
    output logic [9:0]  bad
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] pos = 10'h000;                  // clock position within frame
    logic       oe_d;                           // enable seen at previous edge
    logic [7:0] idx;                            // bit index within frame
    wire  [9:0] len = dbl ? 10'h200 : 10'h100;  // clocks per frame, time-scaled

    // free-running bit clock, unrelated to the system clock
    initial
    begin
        hwy_clk = 1'b0;
        #7;
        forever #24 hwy_clk = ~hwy_clk;
    end

    // strobe high in last clock, so its rise opens the next frame
    always @(posedge hwy_clk)
    begin
        pos          <= (pos >= len - 10'h001) ? 10'h000 : pos + 10'h001;
        frame_strobe <= (pos == len - 10'h002);
    end

    // double rate holds each bit for two clocks
    assign idx = dbl ? pos[8:1] : pos[7:0];

    // own slot gets the word msb first, other slots its inverse
    assign data_rx = rx_word[5'h1f - idx[4:0]] ^ (idx[7:5] != sub);

    // capture on the edge ending each bit, time the enable window
    always @(posedge hwy_clk or posedge rst)
    begin
        if (rst)
        begin
            run     <= 10'h000;
            start   <= 10'h000;
            bad     <= 10'h000;
            oe_d    <= 1'b0;
            tx_word <= 32'h0000_0000;
        end
        else
        begin
            oe_d <= data_tx_oe;
            if (data_tx_oe)
            begin
                run <= oe_d ? run + 10'h001 : 10'h001;
                if (!oe_d)
                    start <= pos;
                if (!dbl || pos[0])
                    tx_word <= {tx_word[30:0], data_tx};
                if (idx[7:5] != sub)
                    bad <= bad + 10'h001;
            end
        end
    end
endmodule
